//--- core/smx_pkg.sv
// Shared types and constants for the static memory access sequencer.
// Assumes a single 10 MHz clock and decoded per-chip-select timings from outside.
package smx_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int LEN_W = 9;
    localparam int ADDR_W = 26;
    localparam int CS_NUM = 6;
    localparam int DLY_REGS = 8;
    localparam int DLY_FIELD_W = 4;
    localparam int DATA_PADS = 32;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Mode encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] WAIT_OFF = 2'h0;
    localparam logic [1:0] WAIT_FROZEN = 2'h2;
    localparam logic [1:0] WAIT_READY = 2'h3;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic BAT_BYTE_SEL = 1'h0;
    localparam logic [3:0] PAGE_BASE_BYTES = 4'h4;
    localparam logic [31:0] DLY_RESET = 32'h0000_0000;
    localparam logic [DLY_FIELD_W-1:0] DLY_NONE = 4'h0;
    localparam logic [DLY_FIELD_W-1:0] DLY_MAX = 4'hF;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LEN_W-1:0] cs_setup;
        logic [LEN_W-1:0] cs_pulse;
        logic [LEN_W-1:0] st_setup;
        logic [LEN_W-1:0] st_pulse;
        logic [LEN_W-1:0] cycle;
    } smx_tim_t;

    typedef struct packed {
        logic [1:0] wait_mode;
        logic page_en;
        logic [1:0] page_size;
        logic byte_access_type;
        logic [1:0] width;
    } smx_mode_t;

    typedef struct packed {
        logic write;
        logic [2:0] cs;
        logic [ADDR_W-1:0] addr;
        logic [3:0] be;
    } smx_req_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RELOAD, ST_RUN, ST_WAITRDY} smx_state_t;

    // Fixed waveforms used while the slow clock indication is high.
    localparam smx_tim_t SLOW_RD_TIM = '{9'h000, 9'h002, 9'h001, 9'h001, 9'h002};
    localparam smx_tim_t SLOW_WR_TIM = '{9'h000, 9'h003, 9'h001, 9'h001, 9'h003};

endpackage

//--- core/smx_sync.sv
// Two-stage level synchroniser for an external input.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/10ps
module smx_sync
    import smx_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic din, // Asynchronous level in.
    output logic dout // Synchronised level out.
);
    logic meta_r;

    // Both stages reset high, the idle level of an active-low input.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // smx_sync

//--- core/smx_static_mem_ctrl.sv
// Access sequencer of the static memory controller: ready-mode wait, slow-clock
// waveforms, page-mode burst reads with page-break detection, and pad delay codes.
// Assumes decoded timings and mode of the addressed chip select arrive on ports.
`timescale 1ns/10ps
module smx_static_mem_ctrl
    import smx_pkg::*;
(
    input wire logic clk, // System clock, 10 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic req_valid, // Access request.
    input wire smx_req_t req, // Request fields.
    input wire smx_tim_t cfg_rd, // Read timings of the addressed select.
    input wire smx_tim_t cfg_wr, // Write timings of the addressed select.
    input wire smx_mode_t cfg_mode, // Mode of the addressed select.
    input wire logic slow_clk_ind, // Slow clock indication, active high.
    input wire logic other_access, // Pulse: another access used the bus.
    input wire logic ext_wait_n, // External wait, active low.
    input wire logic dly_we, // Pad delay register write strobe.
    input wire logic [2:0] dly_idx, // Pad delay register index 0..7.
    input wire logic [31:0] dly_wdata, // Pad delay write data.
    output logic busy, // Access in progress.
    output logic done, // Pulse: access finished.
    output logic page_hit, // Last accepted access was an in-page read.
    output logic [CS_NUM-1:0] chip_sel_n, // Chip selects, active low.
    output logic read_strobe_n, // Read strobe, active low.
    output logic write_strobe_n, // Write strobe, active low.
    output logic [3:0] byte_sel_n, // Byte selects, active low.
    output logic [ADDR_W-1:0] mem_addr, // Memory address.
    output logic [DATA_PADS*DLY_FIELD_W-1:0] pad_dly_data, // Data pad delay codes.
    output logic [ADDR_W*DLY_FIELD_W-1:0] pad_dly_addr // Address pad delay codes.
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    smx_state_t state_r;
    smx_req_t req_r;
    smx_tim_t tim_r;
    smx_tim_t tim_nxt;
    logic [LEN_W-1:0] cnt_r;
    logic ready_r;
    logic page_r;
    logic bat_r;
    logic slow_prev_r;
    logic page_valid_r;
    logic [2:0] page_cs_r;
    logic [ADDR_W-1:0] page_addr_r;
    logic [31:0] dly_r [DLY_REGS];
    logic wait_sync;
    logic take;
    logic page_rd;
    logic hit;
    logic [ADDR_W-1:0] page_mask;
    logic [ADDR_W-1:0] addr_nxt;
    logic [LEN_W:0] pls_end;
    logic [LEN_W:0] cs_end;
    logic sample_pt;
    logic last_cyc;
    logic active;
    logic cs_act;
    logic st_act;

    // ------------------------------------------------------------
    // Wait input synchroniser
    // ------------------------------------------------------------
    smx_sync u_wait_sync (
        .clk(clk),
        .nrst(nrst),
        .din(ext_wait_n),
        .dout(wait_sync)
    );

    // ------------------------------------------------------------
    // Request decode and timing selection
    // ------------------------------------------------------------
    // Page address keeps the bits above the page size; the mask clears the offset.
    assign page_mask = ~(ADDR_W'({PAGE_BASE_BYTES, 4'h0} >> 4 << cfg_mode.page_size) - 26'h000_0001);
    assign take = req_valid && !busy && state_r == ST_IDLE;
    assign page_rd = cfg_mode.page_en && !req.write && !slow_clk_ind;
    assign hit = page_valid_r && page_cs_r == req.cs
        && (page_addr_r & page_mask) == (req.addr & page_mask);

    // Pick slow, page or programmed timings at request acceptance.
    always_comb begin
        addr_nxt = req.addr;
        if (slow_clk_ind) begin
            tim_nxt = req.write ? SLOW_WR_TIM : SLOW_RD_TIM;
        end else if (page_rd) begin
            // Strobe and select share one window; setups are zero and cycle equals the pulse.
            tim_nxt.cs_setup = '0;
            tim_nxt.st_setup = '0;
            tim_nxt.cs_pulse = hit ? cfg_rd.st_pulse : cfg_rd.cs_pulse;
            tim_nxt.st_pulse = tim_nxt.cs_pulse;
            tim_nxt.cycle = tim_nxt.cs_pulse;
            if (cfg_mode.width == WIDTH_16) begin
                addr_nxt[0] = 1'b0;
            end else if (cfg_mode.width == WIDTH_32) begin
                addr_nxt[1:0] = 2'h0;
            end
        end else begin
            tim_nxt = req.write ? cfg_wr : cfg_rd;
        end
    end

    // ------------------------------------------------------------
    // Sequencer position decode
    // ------------------------------------------------------------
    assign pls_end = {1'b0, tim_r.st_setup} + {1'b0, tim_r.st_pulse};
    assign cs_end = {1'b0, tim_r.cs_setup} + {1'b0, tim_r.cs_pulse};
    assign sample_pt = ready_r && {1'b0, cnt_r} + 10'h001 == pls_end;
    assign last_cyc = {1'b0, cnt_r} + 10'h001 >= {1'b0, tim_r.cycle};
    assign active = state_r == ST_RUN || state_r == ST_WAITRDY;
    assign cs_act = active && cnt_r >= tim_r.cs_setup && {1'b0, cnt_r} < cs_end;
    assign st_act = active && cnt_r >= tim_r.st_setup && {1'b0, cnt_r} < pls_end;

    // ------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------
    // Runs setup, pulse and hold by one counter; ready mode may park it.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (take) begin
                        state_r <= (slow_clk_ind != slow_prev_r) ? ST_RELOAD : ST_RUN;
                    end
                end
                ST_RELOAD: begin
                    state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (sample_pt && !wait_sync) begin
                        state_r <= ST_WAITRDY;
                    end else if (last_cyc) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 9'h001;
                    end
                end
                ST_WAITRDY: begin
                    if (wait_sync) begin
                        // Released: resume into the hold step.
                        state_r <= last_cyc ? ST_IDLE : ST_RUN;
                        cnt_r <= last_cyc ? cnt_r : cnt_r + 9'h001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Latch request, timing set and mode flags for the whole transfer.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_r <= '0;
            tim_r <= '0;
            ready_r <= 1'b0;
            page_r <= 1'b0;
            bat_r <= BAT_BYTE_SEL;
            slow_prev_r <= 1'b0;
            page_hit <= 1'b0;
        end else if (take) begin
            req_r <= req;
            req_r.addr <= addr_nxt;
            tim_r <= tim_nxt;
            // Wait mode 00 and frozen mode leave the sequencer untouched here.
            ready_r <= cfg_mode.wait_mode == WAIT_READY && !slow_clk_ind && !page_rd;
            page_r <= page_rd;
            bat_r <= cfg_mode.byte_access_type;
            slow_prev_r <= slow_clk_ind;
            page_hit <= page_rd && hit;
        end
    end

    // Track the open page; a non-page access, or a foreign access in a cycle with no take, breaks it.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            page_valid_r <= 1'b0;
            page_cs_r <= '0;
            page_addr_r <= '0;
        end else if (take) begin
            page_valid_r <= page_rd;
            page_cs_r <= req.cs;
            page_addr_r <= req.addr;
        end else if (other_access) begin
            page_valid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered memory-side outputs
    // ------------------------------------------------------------
    // Outputs follow the counter by one clock so every pin leaves a flip-flop.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            chip_sel_n <= '1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            byte_sel_n <= 4'hF;
            mem_addr <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            chip_sel_n <= '1;
            if (cs_act) begin
                chip_sel_n[req_r.cs] <= 1'b0;
            end
            read_strobe_n <= !(st_act && !req_r.write);
            write_strobe_n <= !(st_act && req_r.write);
            // Byte-select type follows select; byte-write type gates writes only.
            if (bat_r == BAT_BYTE_SEL) begin
                byte_sel_n <= cs_act ? ~req_r.be : 4'hF;
            end else begin
                byte_sel_n <= (st_act && req_r.write) ? ~req_r.be : 4'hF;
            end
            if (active) begin
                mem_addr <= req_r.addr;
            end
            busy <= take || (busy && !done_set());
            done <= done_set();
        end
    end

    // Transfer ends on its last cycle, counted in run or on release.
    function automatic logic done_set();
        done_set = last_cyc && ((state_r == ST_RUN && !(sample_pt && !wait_sync))
            || (state_r == ST_WAITRDY && wait_sync));
    endfunction

    // ------------------------------------------------------------
    // Pad delay registers
    // ------------------------------------------------------------
    // Eight words of 4-bit codes; zero after reset adds no delay.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < DLY_REGS; i++) begin
                dly_r[i] <= DLY_RESET;
            end
        end else if (dly_we) begin
            dly_r[dly_idx] <= dly_wdata;
        end
    end

    // Words 0..3 feed data pads 0..31, words 4..7 address pads 0..25.
    assign pad_dly_data = {dly_r[3], dly_r[2], dly_r[1], dly_r[0]};
    assign pad_dly_addr = {dly_r[7][7:0], dly_r[6], dly_r[5], dly_r[4]};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ready_sample: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_RUN && sample_pt && !wait_sync |=> state_r == ST_WAITRDY)
        else $error("ready wait not taken at pulse end");

    chk_ready_park: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_WAITRDY && !wait_sync |=> state_r == ST_WAITRDY && $stable(cnt_r)
            && $stable(read_strobe_n) && $stable(write_strobe_n))
        else $error("suspended access moved");

    chk_ready_ignore: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_RUN && !sample_pt |=> state_r != ST_WAITRDY)
        else $error("wait honoured outside sample point");

    chk_slow_read: assert property (@(posedge clk) disable iff (!nrst)
        take && slow_clk_ind && !req.write |=> tim_r == SLOW_RD_TIM && !ready_r)
        else $error("slow read timing wrong");

    chk_slow_write: assert property (@(posedge clk) disable iff (!nrst)
        take && slow_clk_ind && req.write |=> tim_r == SLOW_WR_TIM && !ready_r)
        else $error("slow write timing wrong");

    chk_reload_state: assert property (@(posedge clk) disable iff (!nrst)
        take && slow_clk_ind != slow_prev_r |=> state_r == ST_RELOAD ##1 state_r == ST_RUN)
        else $error("reload wait state missing");

    chk_page_short: assert property (@(posedge clk) disable iff (!nrst)
        take && page_rd && hit |=> tim_r.cycle == $past(cfg_rd.st_pulse) && page_hit)
        else $error("in-page access not short");

    chk_page_first: assert property (@(posedge clk) disable iff (!nrst)
        take && page_rd && !hit |=> tim_r.cycle == $past(cfg_rd.cs_pulse) && !page_hit)
        else $error("page break not long");

    chk_page_break: assert property (@(posedge clk) disable iff (!nrst)
        other_access && !take |=> !page_valid_r)
        else $error("foreign access kept page open");

    chk_page_strobe: assert property (@(posedge clk) disable iff (!nrst)
        active && page_r && !req_r.write |=> read_strobe_n == chip_sel_n[$past(req_r.cs)])
        else $error("page strobe and select differ");

    chk_dly_store: assert property (@(posedge clk) disable iff (!nrst)
        dly_we |=> dly_r[$past(dly_idx)] == $past(dly_wdata))
        else $error("delay register not written");

    chk_wait_unused: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_RUN && !ready_r |=> state_r != ST_WAITRDY)
        else $error("wait honoured outside ready mode");

    chk_page_window: assert property (@(posedge clk) disable iff (!nrst)
        take && page_rd |=> tim_r.cs_setup == 9'h000 && tim_r.st_setup == 9'h000
            && tim_r.cycle == tim_r.cs_pulse && tim_r.st_pulse == tim_r.cs_pulse)
        else $error("page read timing not one window");

    chk_slow_no_page: assert property (@(posedge clk) disable iff (!nrst)
        take && slow_clk_ind |=> !page_r && !page_hit)
        else $error("slow access used page timing");

    chk_wait_sync: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst, 2) && $past(nrst) |-> wait_sync == $past(ext_wait_n, 2))
        else $error("wait synchroniser delay wrong");

endmodule // smx_static_mem_ctrl

//--- verification/smx_mem_model.sv
// Behavioural model of the far-side asynchronous memory, reduced to its wait answer.
// Assumes the bench sets wait latency and length between accesses, never during one.
`timescale 1ns/10ps
module smx_mem_model (
    input wire logic clk, // System clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic read_strobe_n, // Read strobe from the controller.
    input wire logic write_strobe_n, // Write strobe from the controller.
    input wire logic [7:0] wait_lat, // Cycles from strobe fall to wait.
    input wire logic [7:0] wait_len, // Cycles the wait is held, zero for none.
    output logic ext_wait_n // Wait to the controller, active low.
);
    logic stb_r;
    logic [7:0] cnt_r;
    // Count cycles since the last strobe fall; the line idles high as if pulled up.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stb_r <= 1'b0;
            cnt_r <= 8'hFF;
            ext_wait_n <= 1'b1;
        end else begin
            stb_r <= !(read_strobe_n && write_strobe_n);
            if (!(read_strobe_n && write_strobe_n) && !stb_r) begin
                cnt_r <= 8'h00;
            end else if (cnt_r != 8'hFF) begin
                cnt_r <= cnt_r + 8'h01;
            end
            ext_wait_n <= !(wait_len != 8'h00 && cnt_r >= wait_lat && cnt_r < wait_lat + wait_len);
        end
    end
endmodule // smx_mem_model

//--- verification/smx_static_mem_ctrl_tb.sv
// Self-checking bench for the static memory access sequencer.
// Assumes the memory model answers the wait line; all other inputs come from here.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module smx_static_mem_ctrl_tb
    import smx_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, slow_clk_ind = 1'b0, other_access = 1'b0, dly_we = 1'b0;
    smx_req_t req = '0;
    smx_tim_t cfg_rd = '0, cfg_wr = '0;
    smx_mode_t cfg_mode = '0;
    logic [2:0] dly_idx = 3'h0;
    logic [31:0] dly_wdata = 32'h0000_0000;
    logic [7:0] wait_lat = 8'h00, wait_len = 8'h00;
    logic ext_wait_n, busy, done, page_hit, read_strobe_n, write_strobe_n;
    logic [CS_NUM-1:0] chip_sel_n;
    logic [3:0] byte_sel_n;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_PADS*DLY_FIELD_W-1:0] pad_dly_data;
    logic [ADDR_W*DLY_FIELD_W-1:0] pad_dly_addr;
    int err_total = 0, n_tests = 0, cyc = 0, len, cs_c, rd_c, wr_c, bs_c, lead, l1;

    // ----------------------------------------
    // Clock, instances and run limit
    // ----------------------------------------
    // Clock of 100 ns period.
    always #50 clk = ~clk;
    smx_static_mem_ctrl u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .slow_clk_ind(slow_clk_ind), .other_access(other_access),
        .ext_wait_n(ext_wait_n), .dly_we(dly_we), .dly_idx(dly_idx), .dly_wdata(dly_wdata), .busy(busy),
        .done(done), .page_hit(page_hit), .chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .byte_sel_n(byte_sel_n), .mem_addr(mem_addr),
        .pad_dly_data(pad_dly_data), .pad_dly_addr(pad_dly_addr));
    smx_mem_model u_mem (.clk(clk), .nrst(nrst), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .wait_lat(wait_lat), .wait_len(wait_len), .ext_wait_n(ext_wait_n));

    // Prints the verdict and stops.
    task end_of_test;
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need a few hundred cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    // One access; counts low cycles of select, strobes and byte selects until done.
    task acc(input logic wr, input logic [2:0] cs, input logic [25:0] a, input logic drop);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{wr, cs, a, 4'hF};
        @(posedge clk);
        req_valid <= 1'b0;
        {len, cs_c, rd_c, wr_c, bs_c, lead} = '0;
        do begin
            @(posedge clk);
            len++;
            if (len == 1) `CHK("busy_on", 1'b1, busy)
            if (drop && len == 1) slow_clk_ind <= 1'b0;
            if (chip_sel_n[cs] === 1'b0 && read_strobe_n && write_strobe_n && rd_c + wr_c == 0) lead++;
            if (chip_sel_n[cs] === 1'b0) cs_c++;
            if (read_strobe_n === 1'b0) rd_c++;
            if (write_strobe_n === 1'b0) wr_c++;
            if (byte_sel_n === 4'h0) bs_c++;
        end while (done !== 1'b1 && len < 300);
        `CHK("done", 1'b1, done)
        `CHK("busy_end", 1'b0, busy)
        @(posedge clk);
    endtask

    // Page read; the expected length comes from the timings in force.
    task pg(input logic [2:0] cs, input logic [25:0] a, input logic hit);
        int ex;
        acc(1'b0, cs, a, 1'b0);
        ex = hit ? int'(cfg_rd.st_pulse) : int'(cfg_rd.cs_pulse);
        `CHK("page_cs", ex, cs_c)
        `CHK("page_rd", ex, rd_c)
        `CHK("page_lead", 0, lead)
        `CHK("page_bs", ex, bs_c)
        `CHK("page_hit", hit, page_hit)
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    // Reset, delay codes, page reads, slow clock, ready wait.
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK("dly_rst", '0, pad_dly_data)
        `CHK("dly_rst_a", '0, pad_dly_addr)
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            dly_we <= 1'b1;
            dly_idx <= 3'(i);
            dly_wdata <= {8{4'(15 - i)}};
        end
        @(posedge clk);
        dly_we <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) `CHK("dly_data", {8{4'(15 - i)}}, pad_dly_data[32*i +: 32])
        for (int i = 4; i < 7; i++) `CHK("dly_addr", {8{4'(15 - i)}}, pad_dly_addr[32*(i-4) +: 32])
        `CHK("dly_a25", 8'h88, pad_dly_addr[96 +: 8])
        cfg_rd <= '{9'h000, 9'h005, 9'h002, 9'h002, 9'h006};
        acc(1'b0, 3'h0, 26'h10, 1'b0);
        `CHK("std_lead", 2, lead)
        `CHK("std_rd", 2, rd_c)
        cfg_rd <= '{9'h003, 9'h005, 9'h002, 9'h002, 9'h009};
        cfg_mode <= '{WAIT_OFF, 1'b1, 2'h1, BAT_BYTE_SEL, 2'h0};
        pg(3'h0, 26'h100, 1'b0);
        pg(3'h0, 26'h107, 1'b1);
        pg(3'h0, 26'h103, 1'b1);
        pg(3'h0, 26'h108, 1'b0);
        @(posedge clk);
        other_access <= 1'b1;
        @(posedge clk);
        other_access <= 1'b0;
        pg(3'h0, 26'h109, 1'b0);
        pg(3'h1, 26'h10A, 1'b0);
        cfg_rd <= '{9'h003, 9'h001, 9'h002, 9'h003, 9'h009};
        pg(3'h1, 26'h10C, 1'b1);
        pg(3'h1, 26'h110, 1'b0);
        for (int p = 0; p < 4; p++) begin
            cfg_mode.page_size <= 2'(p);
            pg(3'(p + 2), 26'h400, 1'b0);
            pg(3'(p + 2), 26'(26'h400 + (4 << p) - 1), 1'b1);
            pg(3'(p + 2), 26'(26'h400 + (4 << p)), 1'b0);
        end
        cfg_mode.width <= WIDTH_32;
        acc(1'b0, 3'h0, 26'h203, 1'b0);
        `CHK("addr32", 26'h200, mem_addr)
        cfg_mode.width <= WIDTH_16;
        acc(1'b0, 3'h0, 26'h203, 1'b0);
        `CHK("addr16", 26'h202, mem_addr)
        cfg_mode <= '{WAIT_OFF, 1'b0, 2'h0, BAT_BYTE_SEL, 2'h0};
        cfg_wr <= '{9'h000, 9'h004, 9'h000, 9'h004, 9'h005};
        slow_clk_ind <= 1'b1;
        acc(1'b0, 3'h0, 26'h20, 1'b0);
        l1 = len;
        acc(1'b0, 3'h0, 26'h20, 1'b0);
        `CHK("reload_in", 1, l1 - len)
        `CHK("slow_rd_cs", 2, cs_c)
        `CHK("slow_rd_st", 1, rd_c)
        `CHK("slow_rd_setup", 1, lead)
        acc(1'b1, 3'h3, 26'h20, 1'b0);
        `CHK("slow_wr_cs", 3, cs_c)
        `CHK("slow_wr_st", 1, wr_c)
        `CHK("slow_wr_setup", 1, lead)
        acc(1'b1, 3'h3, 26'h20, 1'b1);
        `CHK("leave_cs", 3, cs_c)
        `CHK("leave_st", 1, wr_c)
        acc(1'b1, 3'h3, 26'h20, 1'b0);
        l1 = len;
        acc(1'b1, 3'h3, 26'h20, 1'b0);
        `CHK("reload_out", 1, l1 - len)
        `CHK("fast_wr_st", 4, wr_c)
        // Byte-write type: byte selects only under the write strobe, never on reads.
        cfg_mode.byte_access_type <= 1'b1;
        acc(1'b0, 3'h3, 26'h20, 1'b0);
        `CHK("bat_rd_bs", 0, bs_c)
        acc(1'b1, 3'h3, 26'h20, 1'b0);
        `CHK("bat_wr_bs", 4, bs_c)
        cfg_wr <= '{9'h000, 9'h009, 9'h000, 9'h008, 9'h00A};
        wait_lat <= 8'h01;
        wait_len <= 8'h08;
        acc(1'b1, 3'h0, 26'h0, 1'b0);
        l1 = len;
        `CHK("wait_off", 8, wr_c)
        cfg_mode.wait_mode <= WAIT_READY;
        acc(1'b1, 3'h0, 26'h0, 1'b0);
        // Synced wait stays low seven cycles past the sample point, so the strobe stretches by seven.
        `CHK("wait_ext", 15, wr_c)
        `CHK("wait_hold", wr_c - 8, len - l1)
        wait_len <= 8'h01;
        acc(1'b1, 3'h0, 26'h0, 1'b0);
        `CHK("wait_early", 8, wr_c)
        wait_lat <= 8'h09;
        wait_len <= 8'h03;
        acc(1'b1, 3'h0, 26'h0, 1'b0);
        `CHK("wait_late", 8, wr_c)
        end_of_test();
    end
endmodule // smx_static_mem_ctrl_tb
